// ---- include/clkbuf_cfg_pkg.sv ----
// Purpose: shared constants, states and carriers of the clock buffer config bank
// Assumes: eight byte locations reached over the serial management link
// Notes:   a mask bit of 1 marks a bit that the link may change
package clkbuf_cfg_pkg;
   localparam int         BANK_BYTES   = 8;
   localparam int         Q_COUNT      = 6;
   localparam int         STRAP_SETTLE = 2;
   localparam logic [7:0] LOC_OE       = 8'h00;
   localparam logic [7:0] LOC_PLL      = 8'h01;
   localparam logic [7:0] LOC_SLEW     = 8'h02;
   localparam logic [7:0] LOC_FREQ     = 8'h03;
   localparam logic [7:0] LOC_RSV4     = 8'h04;
   localparam logic [7:0] LOC_REV      = 8'h05;
   localparam logic [7:0] LOC_DEVID    = 8'h06;
   localparam logic [7:0] LOC_RSV7     = 8'h07;
   localparam logic [7:0] RST_OE       = 8'hdd;
   localparam logic [7:0] RST_PLL      = 8'h06;
   localparam logic [7:0] RST_SLEW     = 8'hff;
   localparam logic [7:0] RST_FREQ     = 8'hc7;
   localparam logic [7:0] RST_RSV4     = 8'hff;
   localparam logic [7:0] RST_RSV7     = 8'h08;
   localparam logic [1:0] RST_CLASS    = 2'h1;
   localparam logic [3:0] SMB_ADDR_HI  = 4'hd;
   localparam int         B1_RB_LSB    = 6;
   localparam int         B1_SWCTL     = 5;
   localparam int         B1_SW_LSB    = 3;
   localparam int         B3_FSEL_EN   = 5;
   localparam int         B3_FSEL_LSB  = 3;
   localparam int         B3_FB_SLEW   = 0;
   // per-output bit position in the enable and slew bytes, Q0 first
   localparam int         Q_BIT [Q_COUNT] = '{0, 2, 3, 4, 6, 7};

   typedef logic [BANK_BYTES-1:0][7:0] bank_t;
   localparam bank_t WR_MASK = {8'h00, 8'hff, 8'h00, 8'h00, 8'h39, 8'hdd, 8'h3b, 8'hdd};

   typedef enum logic [1:0] {AMP_0V60, AMP_0V68, AMP_0V75, AMP_0V85} amp_t;
   typedef enum logic [1:0] {STOP_LOW_LOW, STOP_HIZ, STOP_HIGH_LOW, STOP_LOW_HIGH} stop_t;
   typedef enum logic [2:0] {PH_ADDR, PH_LOC, PH_CNT, PH_WDATA,
                             PH_RSTART, PH_RCNT, PH_RDATA, PH_IGNORE} phase_t;

   typedef struct packed {
      logic [7:0] loc;
      logic [7:0] data;
   } bank_wr_t;

   typedef struct packed {
      logic [5:0] oe_n;
      logic [1:0] stop;
      logic [1:0] bw;
      logic [2:0] adr;
      logic       scl;
      logic       sda_low;
      logic       wr_tog;
   } pin_t;
endpackage

// ---- rtl/bit_sync2.sv ----
`timescale 1ns/1ns
// Purpose: two-flop synchroniser for a group of levels
// Assumes: each bit is an independent level or a slow toggle
// Notes:   the first stage feeds only the second stage
module bit_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] meta_r;

   if (W < 1) begin : g_bad_width
      $error("bit_sync2 needs a positive width");
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// ---- rtl/smb_link.sv ----
`timescale 1ns/1ns
// Purpose: serial link engine on the link clock, block read and block write
// Assumes: bank image and device address are static while a frame runs
// Notes:   the link clock stops between frames, so reset is applied without it
module smb_link import clkbuf_cfg_pkg::*; (
   input  wire logic       scl,
   input  wire logic       rst,
   input  wire logic       sda_in,
   input  wire logic [6:0] dev_addr,
   input  wire bank_t      rd_bank,
   output bank_wr_t        wr,
   output logic            wr_tog,
   output logic            sda_low
);
   logic       start_tog_r;
   logic       start_seen_r;
   phase_t     ph_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r;
   logic [7:0] tx_r;
   logic [7:0] loc_r;
   logic [7:0] left_r;
   logic [7:0] byte_in;
   logic [7:0] nxt_byte;
   logic       new_frame;
   logic       rd_ph;

   assign byte_in   = {sh_r[6:0], sda_in};
   assign new_frame = start_tog_r ^ start_seen_r;
   assign rd_ph     = (ph_r == PH_RCNT) || (ph_r == PH_RDATA);

   // start or repeated start: data falls while the clock is high
   always_ff @(negedge sda_in or posedge rst) begin
      if (rst) begin
         start_tog_r <= 1'b0;
      end else if (scl) begin
         start_tog_r <= ~start_tog_r;
      end
   end

   always_comb begin
      nxt_byte = 8'h00;
      if (ph_r == PH_RSTART) begin
         if (loc_r < 8'(BANK_BYTES)) nxt_byte = 8'(BANK_BYTES) - loc_r;
      end else if (loc_r < 8'(BANK_BYTES)) begin
         nxt_byte = rd_bank[loc_r[2:0]];
      end
   end

   always_ff @(posedge scl or posedge rst) begin
      if (rst) begin
         start_seen_r <= 1'b0;
         ph_r         <= PH_IGNORE;
         cnt_r        <= 4'h0;
         sh_r         <= 8'h00;
         tx_r         <= 8'h00;
         loc_r        <= 8'h00;
         left_r       <= 8'h00;
         wr           <= '0;
         wr_tog       <= 1'b0;
         sda_low      <= 1'b0;
      end else begin
         start_seen_r <= start_tog_r;
         if (new_frame) begin
            ph_r    <= PH_ADDR;
            cnt_r   <= 4'h1;
            sh_r    <= {7'h00, sda_in};
            sda_low <= 1'b0;
         end else if (cnt_r == 4'h8) begin
            cnt_r <= 4'h0;
            if (ph_r == PH_RSTART || (rd_ph && !sda_in)) begin
               tx_r    <= nxt_byte;
               sda_low <= ~nxt_byte[7];
               ph_r    <= (ph_r == PH_RSTART) ? PH_RCNT : PH_RDATA;
               if (ph_r != PH_RSTART) loc_r <= loc_r + 8'h01;
            end else begin
               // a not-acknowledge from the host ends the read
               sda_low <= 1'b0;
               if (rd_ph) ph_r <= PH_IGNORE;
            end
         end else begin
            cnt_r <= cnt_r + 4'h1;
            sh_r  <= byte_in;
            if (rd_ph) begin
               tx_r    <= {tx_r[6:0], 1'b0};
               sda_low <= (cnt_r == 4'h7) ? 1'b0 : ~tx_r[6];
            end else if (cnt_r == 4'h7) begin
               case (ph_r)
                  PH_ADDR: begin
                     if (byte_in[7:1] == dev_addr) begin
                        sda_low <= 1'b1;
                        ph_r    <= byte_in[0] ? PH_RSTART : PH_LOC;
                     end else begin
                        ph_r <= PH_IGNORE;
                     end
                  end
                  PH_LOC: begin
                     loc_r   <= byte_in;
                     sda_low <= 1'b1;
                     ph_r    <= PH_CNT;
                  end
                  PH_CNT: begin
                     left_r  <= byte_in;
                     sda_low <= 1'b1;
                     ph_r    <= PH_WDATA;
                  end
                  PH_WDATA: begin
                     // each whole byte commits on its own
                     if (left_r != 8'h00) begin
                        wr      <= '{loc: loc_r, data: byte_in};
                        wr_tog  <= ~wr_tog;
                        loc_r   <= loc_r + 8'h01;
                        left_r  <= left_r - 8'h01;
                        sda_low <= 1'b1;
                     end else begin
                        ph_r <= PH_IGNORE;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   a_addr_mismatch: assert property (@(posedge scl) disable iff (rst)
      (!new_frame && ph_r == PH_ADDR && cnt_r == 4'h7 && byte_in[7:1] != dev_addr)
      |=> !sda_low && ph_r == PH_IGNORE)
      else $error("link acknowledged a foreign address");

   a_whole_byte_only: assert property (@(posedge scl) disable iff (rst)
      $changed(wr_tog) |-> $past(cnt_r) == 4'h7 && $past(ph_r) == PH_WDATA)
      else $error("write committed before a whole byte");
endmodule

// ---- rtl/clkbuf_cfg.sv ----
`timescale 1ns/1ns
// Purpose: configuration bytes 0..7 of a six-output differential clock buffer
// Assumes: MCLK 100 MHz; SMB_CLK is the link clock and stops between frames
// Notes:   strap pins arrive already decoded to two-state codes
module clkbuf_cfg import clkbuf_cfg_pkg::*; #(
   parameter logic [3:0] REVISION_CODE = 4'ha, // arbitrary value
   parameter logic [3:0] VENDOR_CODE   = 4'h5, // arbitrary value
   parameter logic [5:0] DEVICE_ID     = 6'h2a // arbitrary value
) (
   input  wire logic       MCLK,
   input  wire logic       SYS_RST,
   input  wire logic       SMB_CLK,
   input  wire logic       SDA_IN,
   output logic            SDA_OUT,
   output logic            SDA_OE_N,
   input  wire logic [5:0] OE_N,
   input  wire logic [1:0] STOP_SEL,
   input  wire logic [1:0] BANDWIDTH_STRAP_PIN,
   input  wire logic [2:0] ADDRESS_STRAP_PIN,
   output logic [5:0]      OUT_RUN,
   output logic [5:0]      OUT_TRUE_LVL,
   output logic [5:0]      OUT_COMP_LVL,
   output logic [5:0]      OUT_HIZ,
   output logic [5:0]      SLEW_FAST,
   output logic            FB_SLEW_FAST,
   output logic [1:0]      PLL_MODE,
   output logic [1:0]      AMPLITUDE,
   output logic            FREQ_SW_EN,
   output logic [1:0]      FREQ_CODE
);
   localparam bank_t RST_BANK = {RST_RSV7, RST_CLASS, DEVICE_ID,
                                 REVISION_CODE, VENDOR_CODE, RST_RSV4,
                                 RST_FREQ, RST_SLEW, RST_PLL, RST_OE};

   pin_t       pins_raw;
   pin_t       pins_s;
   bank_wr_t   lnk_wr;
   logic       lnk_wr_tog;
   logic       lnk_sda_low;
   logic [1:0] settle_r;
   logic       strap_done_r;
   logic [1:0] pll_rb_r;
   logic [2:0] addr_lo_r;
   logic       tog_seen_r;
   logic       wr_hit;
   bank_t      bank_r;
   bank_t      rd_image;
   logic [5:0] q_en;
   logic [5:0] q_slew;
   logic [5:0] q_on;
   logic       sw_mode_on;
   logic       fsel_on;

   assign pins_raw = '{oe_n: OE_N, stop: STOP_SEL, bw: BANDWIDTH_STRAP_PIN,
                       adr: ADDRESS_STRAP_PIN, scl: SMB_CLK,
                       sda_low: lnk_sda_low, wr_tog: lnk_wr_tog};

   bit_sync2 #(.W($bits(pin_t))) u_sync (
      .clk (MCLK),
      .rst (SYS_RST),
      .d   (pins_raw),
      .q   (pins_s)
   );

   // link domain sees the bank and address as static: they only move on
   // link writes themselves, or once just after reset
   smb_link u_link (
      .scl      (SMB_CLK),
      .rst      (SYS_RST),
      .sda_in   (SDA_IN),
      .dev_addr ({SMB_ADDR_HI, addr_lo_r}),
      .rd_bank  (rd_image),
      .wr       (lnk_wr),
      .wr_tog   (lnk_wr_tog),
      .sda_low  (lnk_sda_low)
   );

   // straps are caught once the synchronisers hold settled pin levels
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         settle_r     <= 2'h0;
         strap_done_r <= 1'b0;
         pll_rb_r     <= 2'h0;
         addr_lo_r    <= 3'h0;
      end else if (!strap_done_r) begin
         if (settle_r == 2'(STRAP_SETTLE)) begin
            strap_done_r <= 1'b1;
            pll_rb_r     <= pins_s.bw;
            addr_lo_r    <= pins_s.adr;
         end else begin
            settle_r <= settle_r + 2'h1;
         end
      end
   end

   // write data stays put for a whole byte time after its toggle
   assign wr_hit = pins_s.wr_tog ^ tog_seen_r;

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         tog_seen_r <= 1'b0;
      end else begin
         tog_seen_r <= pins_s.wr_tog;
      end
   end

   // read-only and reserved bits keep their reset value through the mask
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         bank_r <= RST_BANK;
      end else if (wr_hit && lnk_wr.loc < 8'(BANK_BYTES)) begin
         bank_r[lnk_wr.loc[2:0]] <=
            (lnk_wr.data & WR_MASK[lnk_wr.loc[2:0]]) |
            (bank_r[lnk_wr.loc[2:0]] & ~WR_MASK[lnk_wr.loc[2:0]]);
      end
   end

   always_comb begin
      rd_image = bank_r;
      rd_image[LOC_PLL[2:0]][7:B1_RB_LSB] = pll_rb_r;
   end

   for (genvar i = 0; i < Q_COUNT; i++) begin : g_out
      assign q_en[i]   = bank_r[LOC_OE[2:0]][Q_BIT[i]];
      assign q_slew[i] = bank_r[LOC_SLEW[2:0]][Q_BIT[i]];
      assign q_on[i]   = q_en[i] & ~pins_s.oe_n[i];
   end

   assign sw_mode_on = bank_r[LOC_PLL[2:0]][B1_SWCTL];
   assign fsel_on    = bank_r[LOC_FREQ[2:0]][B3_FSEL_EN];

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         OUT_RUN      <= 6'h00;
         OUT_TRUE_LVL <= 6'h00;
         OUT_COMP_LVL <= 6'h00;
         OUT_HIZ      <= 6'h00;
      end else begin
         OUT_RUN      <= q_on;
         OUT_TRUE_LVL <= 6'h00;
         OUT_COMP_LVL <= 6'h00;
         OUT_HIZ      <= 6'h00;
         case (stop_t'(pins_s.stop))
            STOP_HIZ:      OUT_HIZ      <= ~q_on;
            STOP_HIGH_LOW: OUT_TRUE_LVL <= ~q_on;
            STOP_LOW_HIGH: OUT_COMP_LVL <= ~q_on;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         PLL_MODE  <= 2'h0;
         AMPLITUDE <= AMP_0V75;
      end else begin
         // stored software mode bits matter only under override
         PLL_MODE  <= sw_mode_on ?
                      bank_r[LOC_PLL[2:0]][B1_SW_LSB +: 2] : pll_rb_r;
         AMPLITUDE <= bank_r[LOC_PLL[2:0]][1:0];
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         SLEW_FAST    <= 6'h3f;
         FB_SLEW_FAST <= 1'b1;
         FREQ_SW_EN   <= 1'b0;
         FREQ_CODE    <= 2'h0;
      end else begin
         SLEW_FAST    <= q_slew;
         FB_SLEW_FAST <= bank_r[LOC_FREQ[2:0]][B3_FB_SLEW];
         FREQ_SW_EN   <= fsel_on;
         FREQ_CODE    <= fsel_on ?
                         bank_r[LOC_FREQ[2:0]][B3_FSEL_LSB +: 2] : 2'h0;
      end
   end

   // data may only move while the link clock is low, or it would
   // look like a start or stop to the host
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         SDA_OE_N <= 1'b1;
         SDA_OUT  <= 1'b0;
      end else begin
         SDA_OUT <= 1'b0;
         if (!pins_s.scl) SDA_OE_N <= ~pins_s.sda_low;
      end
   end

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (SYS_RST);

   a_enable_bit_stop: assert property (
      1 |=> ((OUT_RUN & ~$past(q_en)) == 6'h00))
      else $error("output runs with its enable bit clear");

   a_stop_low_low: assert property (
      (pins_s.stop == STOP_LOW_LOW) |=>
         ((OUT_TRUE_LVL | OUT_COMP_LVL | OUT_HIZ) == 6'h00))
      else $error("stopped output not low on both legs");

   a_strap_readback: assert property (
      strap_done_r |=> $stable(pll_rb_r) &&
         rd_image[LOC_PLL[2:0]][7:6] == pll_rb_r)
      else $error("pll readback moved after the strap latch");

   a_mode_from_strap: assert property (
      !sw_mode_on [*2] |-> PLL_MODE == $past(pll_rb_r))
      else $error("pll mode not taken from the strap");

   a_sw_mode_inert: assert property (
      (wr_hit && lnk_wr.loc == LOC_PLL && !lnk_wr.data[B1_SWCTL])
      |=> ##1 PLL_MODE == pll_rb_r)
      else $error("software mode bits acted without override");

   a_amp_follow: assert property (
      $changed(bank_r[LOC_PLL[2:0]][1:0]) |=>
         AMPLITUDE == $past(bank_r[LOC_PLL[2:0]][1:0]))
      else $error("amplitude output lags its code");

   a_slew_bits_map: assert property (
      (wr_hit && lnk_wr.loc == LOC_SLEW) |=> ##1
         SLEW_FAST == {$past(lnk_wr.data[7], 2), $past(lnk_wr.data[6], 2),
                       $past(lnk_wr.data[4], 2), $past(lnk_wr.data[3], 2),
                       $past(lnk_wr.data[2], 2), $past(lnk_wr.data[0], 2)})
      else $error("slew bits landed on the wrong outputs");

   a_freq_gated: assert property (
      !fsel_on |=> FREQ_CODE == 2'h0 && !FREQ_SW_EN)
      else $error("frequency code leaked while disabled");

   a_fb_slew_write: assert property (
      (wr_hit && lnk_wr.loc == LOC_FREQ) |=> ##1
         FB_SLEW_FAST == $past(lnk_wr.data[B3_FB_SLEW], 2))
      else $error("feedback slew did not follow its bit");

   a_id_byte_fixed: assert property (
      rd_image[LOC_REV[2:0]] == {REVISION_CODE, VENDOR_CODE})
      else $error("revision and vendor byte changed");

   a_devid_write: assert property (
      (wr_hit && lnk_wr.loc == LOC_DEVID) |=>
         bank_r[LOC_DEVID[2:0]] == $past(lnk_wr.data))
      else $error("device class and identifier not stored");

   a_sda_on_low_clock: assert property (
      $changed(SDA_OE_N) |-> !$past(pins_s.scl))
      else $error("data line moved while the link clock was high");

   c_write_seen: cover property (wr_hit && lnk_wr.loc == LOC_OE);
   c_sw_mode_used: cover property (sw_mode_on ##1 PLL_MODE != pll_rb_r);
   c_bit_stop: cover property (!q_en[0] && !pins_s.oe_n[0]);
   c_ack_driven: cover property (!SDA_OE_N);
endmodule

// ---- dv/smb_host_model.sv ----
// Purpose: serial management host that frames block reads and writes
// Assumes: data line has a pull-up; host only pulls low or releases
// Notes:   clock stands high between frames; half is raised for a slow host
`timescale 1ns/1ns
module smb_host_model (
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda_in
);
   logic tick;
   int   half = 6;

   // 12 ns base tick, offset by 3 ns; its rising edges still meet system clock rising edges every 60 ns
   initial begin
      tick = 1'b0;
      scl = 1'b1;
      sda_low = 1'b0;
      #3;
      forever #6 tick = ~tick;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge tick);
   endtask

   // data changes mid-low and is sampled mid-high, msb first
   task automatic xfer(input logic b, output logic r);
      wt(half / 2);
      sda_low = ~b;
      wt(half - half / 2);
      scl = 1'b1;
      wt(half / 2);
      r = sda_in;
      wt(half - half / 2);
      scl = 1'b0;
   endtask

   task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
                          output logic k);
      for (int i = 7; i >= 0; i--) begin
         xfer(d[i], q[i]);
      end
      xfer(a, k);
   endtask

   // serves as start and as repeated start
   task automatic start();
      wt(half / 2);
      sda_low = 1'b0;
      wt(half / 2);
      scl = 1'b1;
      wt(half);
      sda_low = 1'b1;
      wt(half);
      scl = 1'b0;
   endtask

   // may follow any whole byte, ending the transfer early
   task automatic stop();
      wt(half / 2);
      sda_low = 1'b1;
      wt(half / 2);
      scl = 1'b1;
      wt(half);
      sda_low = 1'b0;
      wt(half);
   endtask
endmodule

// ---- dv/clock_buffer_config_registers_tb.sv ----
// Purpose: self-checking bench of the clock buffer config bank
// Assumes: host model drives the link; bank image mirrored here
// Notes:   expected values come from the byte masks and reset values
`timescale 1ns/1ns
module clock_buffer_config_registers_tb import clkbuf_cfg_pkg::*;;
   localparam logic [3:0] REV = 4'h9;  // arbitrary value
   localparam logic [3:0] VEN = 4'h6;  // arbitrary value
   localparam logic [5:0] DID = 6'h15; // arbitrary value
   logic       mclk, sys_rst, scl, sda_low, sda_in, sda_oe_n, fb_o, fen_o, sda_o;
   logic [5:0] oe_n, run_o, tl_o, cl_o, hz_o, sf_o;
   logic [1:0] stop_sel, pll_o, amp_o, fc_o;
   logic [1:0] bw = 2'h2;
   logic [2:0] ad = 3'h5;
   logic [6:0] dev;
   logic [7:0] mdl [BANK_BYTES];
   logic [7:0] wq [$];
   int         seed = 62, r, err_count, num_checks, cyc;

   // open-drain wire with pull-up
   assign sda_in = ~(sda_low | ~sda_oe_n);
   assign dev = {SMB_ADDR_HI, ad};

   clkbuf_cfg #(.REVISION_CODE(REV), .VENDOR_CODE(VEN), .DEVICE_ID(DID)) DUT (
      .MCLK(mclk), .SYS_RST(sys_rst), .SMB_CLK(scl), .SDA_IN(sda_in), .SDA_OUT(sda_o),
      .SDA_OE_N(sda_oe_n), .OE_N(oe_n), .STOP_SEL(stop_sel),
      .BANDWIDTH_STRAP_PIN(bw), .ADDRESS_STRAP_PIN(ad), .OUT_RUN(run_o),
      .OUT_TRUE_LVL(tl_o), .OUT_COMP_LVL(cl_o), .OUT_HIZ(hz_o), .SLEW_FAST(sf_o),
      .FB_SLEW_FAST(fb_o), .PLL_MODE(pll_o), .AMPLITUDE(amp_o), .FREQ_SW_EN(fen_o),
      .FREQ_CODE(fc_o)
   );
   smb_host_model host (.scl(scl), .sda_low(sda_low), .sda_in(sda_in));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic check(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // a hang of the link is cut off well beyond the expected run length
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         finish_test();
      end
   end

   task automatic set_pins(input logic [1:0] s);
      @(posedge mclk);
      #1;
      r = $random(seed);
      oe_n = r[5:0];
      stop_sel = s;
      repeat (6) @(posedge mclk);
   endtask

   task automatic wr_frame(input logic [6:0] a, input logic [7:0] loc, input int cnt);
      logic [7:0] q;
      logic       k, m;
      logic [7:0] h [3];
      h = '{{a, 1'b0}, loc, cnt[7:0]};
      m = (a == dev);
      host.start();
      foreach (h[i]) begin
         host.byte_io(h[i], 1'b1, q, k);
         check({7'h0, k}, {7'h0, ~m});
      end
      foreach (wq[j]) begin
         host.byte_io(wq[j], 1'b1, q, k);
         check({7'h0, k}, {7'h0, ~(m && j < cnt)});
         if (m && j < cnt && loc + j < 8)
            mdl[loc + j] = (mdl[loc + j] & ~WR_MASK[loc + j]) | (wq[j] & WR_MASK[loc + j]);
      end
      host.stop();
      repeat (8) @(posedge mclk);
   endtask

   task automatic rd_frame(input logic [7:0] loc, input int n);
      logic [7:0] q;
      logic       k;
      host.start();
      host.byte_io({dev, 1'b0}, 1'b1, q, k);
      host.byte_io(loc, 1'b1, q, k);
      host.start();
      host.byte_io({dev, 1'b1}, 1'b1, q, k);
      check({7'h0, k}, 8'h00);
      host.byte_io(8'hff, n == 0, q, k);
      check(q, loc < 8 ? 8'(8 - loc) : 8'h00);
      for (int j = 0; j < n; j++) begin
         host.byte_io(8'hff, j == n - 1, q, k);
         check(q, mdl[loc + j]);
      end
      host.stop();
   endtask

   task automatic check_outs();
      logic [5:0] run, sf;
      for (int i = 0; i < Q_COUNT; i++) begin
         run[i] = mdl[0][Q_BIT[i]] & ~oe_n[i];
         sf[i] = mdl[2][Q_BIT[i]];
      end
      check({2'h0, run_o}, {2'h0, run});
      check({2'h0, tl_o}, {2'h0, ~run & {6{stop_sel == 2'h2}}});
      check({2'h0, cl_o}, {2'h0, ~run & {6{stop_sel == 2'h3}}});
      check({2'h0, hz_o}, {2'h0, ~run & {6{stop_sel == 2'h1}}});
      check({2'h0, sf_o}, {2'h0, sf});
      check({7'h0, fb_o}, {7'h0, mdl[3][0]});
      check({6'h0, pll_o}, {6'h0, mdl[1][5] ? mdl[1][4:3] : bw});
      check({6'h0, amp_o}, {6'h0, mdl[1][1:0]});
      check({7'h0, fen_o}, {7'h0, mdl[3][5]});
      check({6'h0, fc_o}, {6'h0, mdl[3][5] ? mdl[3][4:3] : 2'h0});
      check({7'h0, sda_o}, 8'h00);
   endtask

   task automatic fill(input int n);
      wq.delete();
      repeat (n) begin
         r = $random(seed);
         wq.push_back(r[7:0]);
      end
   endtask

   initial begin
      sys_rst = 1'b1;
      oe_n = 6'h00;
      stop_sel = 2'h0;
      mdl = '{8'hdd, {bw, 6'h06}, 8'hff, 8'hc7, 8'hff, {REV, VEN}, {2'h1, DID}, 8'h08};
      repeat (2) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      repeat (12) @(posedge mclk);
      rd_frame(8'h00, 8);
      check_outs();
      $display("test reset done");
      // every amplitude, stop and class code, overrides on and off; software mode bits random
      for (int k = 0; k < 4; k++) begin
         set_pins(k[1:0]);
         fill(7);
         wq[1][1:0] = k[1:0];
         wq[1][5] = k[0];
         wq[3][5] = k[1];
         wq[6][7:6] = k[1:0];
         wr_frame(dev, 8'h00, 7);
         rd_frame(8'h00, 8);
         check_outs();
      end
      $display("test codes done");
      set_pins(2'h2);
      fill(2);
      wr_frame(dev, 8'h00, 4);
      rd_frame(8'h00, 4);
      check_outs();
      $display("test early stop done");
      fill(3);
      wr_frame(dev, 8'h06, 1);
      fill(3);
      wr_frame(dev, 8'h07, 3);
      rd_frame(8'h09, 0);
      rd_frame(8'h05, 3);
      $display("test refusals done");
      host.half = 12;
      fill(2);
      wr_frame(dev ^ 7'h01, 8'h00, 2);
      rd_frame(8'h00, 8);
      host.half = 6;
      check_outs();
      $display("test foreign address done");
      finish_test();
   end
endmodule
